// ### design/ccd_regs.vh
// register map, field layout and constants of the code domain checker
`ifndef CCD_REGS_VH
`define CCD_REGS_VH

// byte offsets on the register bus
`define CCD_ADDR_CTRL 8'h00
`define CCD_ADDR_STATUS 8'h04
`define CCD_ADDR_FIRST 8'h08
`define CCD_ADDR_LAST 8'h0C
`define CCD_ADDR_GCFG 8'h10
`define CCD_ADDR_GCODE 8'h14
`define CCD_ADDR_GPWR 8'h18
`define CCD_ADDR_GTIM 8'h1C
`define CCD_ADDR_ROWSEL 8'h20
`define CCD_ADDR_ROWDATA 8'h24
`define CCD_ADDR_ROWINFO 8'h28
`define CCD_ADDR_POSSEL 8'h2C
`define CCD_ADDR_POSCNT 8'h30
`define CCD_ADDR_ROWTIME 8'h34

// control bits
`define CCD_CTRL_EXEC 0
`define CCD_CTRL_RESOLVE 1
// status bits
`define CCD_STAT_BUSY 0
`define CCD_STAT_CONFLICT 1
`define CCD_STAT_UNRES 2

// group configuration fields
`define CCD_GCFG_RATE_LSB 0
`define CCD_GCFG_PIL_LSB 4
`define CCD_GCFG_DSRC_LSB 8
`define CCD_GCFG_MCODE 12
`define CCD_GCFG_STATE 13
`define CCD_GCODE_STEP_LSB 16
`define CCD_GPWR_STEP_LSB 8
`define CCD_GTIM_STEP_LSB 8

// row numbering and code domain
`define CCD_ROW_MIN 8'h0B
`define CCD_ROW_MAX 8'h8A
`define CCD_DOMAIN_LAST 9'h1FF
`define CCD_DOMAIN_SIZE 15'h0200
`define CCD_SF_MAX 10'h200

// power limits in dB, two's complement
`define CCD_PWR_MIN 9'h1C4
`define CCD_PWR_MAX 9'h000
`define CCD_PSTEP_MIN 9'h1C4
`define CCD_PSTEP_MAX 9'h03C

// timing offset unit is 256 chips
`define CCD_TOFF_SHIFT 8
// slot bits at the lowest symbol rate
`define CCD_SLOT_BITS_MIN 11'h00A

// reset values
`define CCD_FIRST_RST 8'h0B
`define CCD_LAST_RST 8'h0B
`define CCD_GCFG_RST 14'h2212
`define CCD_GCODE_RST 32'h0000_0000
`define CCD_GPWR_RST 16'h0000
`define CCD_GTIM_RST 16'h0000

`endif

// ### design/ccd_checker.v
// group configuration expander and code domain conflict checker
//
// Notes on behaviour
// [RULE1] pilot length 2 to 16 bits, upper limit depends on symbol rate
// [RULE2] data field bits equal slot bits minus pilot bits
// [RULE3] first row gets start code, each next row previous code plus step
// [RULE4] start power -60..0 dB, step -60..60 dB, added row by row
// [RULE5] frame start delay equals timing offset times 256 chips
// [RULE6] each next row timing offset is previous plus offset step
// [RULE7] software should prefer nonzero timing offset to lower crest factor
// [RULE8] group state marks every row in range active or inactive
// [RULE9] group multicode setting stored for every row in range
// [RULE10] execute writes every row from first through last inclusive
// [RULE11] spreading factor equals chip rate over symbol rate
// [RULE12] a code occupies all longer codes below it in its branch
// [RULE13] code domain spans positions 0 through 511
// [RULE14] domain factor is symbol rate over 7.5 ksps
// [RULE15] lower domain bound is code number times domain factor
// [RULE16] upper bound is lower bound plus factor minus one
// [RULE17] overlap of two active rows is a conflict
// [RULE18] one station wide flag shows any conflict
// [RULE19] a row is flagged when it overlaps an active lower row
// [RULE20] each position reports single or multiple occupancy
// [RULE21] resolve changes only code numbers of active rows
// [RULE22] resolve fails with a flag when total domain exceeds 512
// [RULE23] first and last row numbers accept only 11 through 138
// [RULE24] occupancy is two bit saturating count, rebuilt after changes
// [RULE25] inactive rows take no part in counting, flags or resolve
`timescale 1ns/1ps
`default_nettype none
`include "ccd_regs.vh"

module ccd_checker (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // status
  output reg conflict,
  output reg unresolvable,
  output wire busy
);

  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_EXEC = 6'h02;
  localparam [5:0] S_CLEAR = 6'h04;
  localparam [5:0] S_SCAN = 6'h08;
  localparam [5:0] S_SUM = 6'h10;
  localparam [5:0] S_ASSIGN = 6'h20;
  // rate index 0..7 stands for 7.5 ksps .. 960 ksps
  function [7:0] dom_factor; // [RULE14]
    input [2:0] rate;
    begin
      dom_factor = 8'h01 << rate;
    end
  endfunction
  function [8:0] code_mask; // [RULE13]
    input [8:0] code;
    input [2:0] rate;
    begin
      code_mask = code & (`CCD_DOMAIN_LAST >> rate);
    end
  endfunction

  // higher rates carry more pilot bits, low rates cap at 4 or 8
  function [1:0] pilot_fit; // [RULE1]
    input [1:0] pil;
    input [2:0] rate;
    reg [1:0] lim;
    begin
      lim = (rate < 3'h2) ? 2'h1 : ((rate < 3'h4) ? 2'h2 : 2'h3);
      pilot_fit = (pil > lim) ? lim : pil;
    end
  endfunction

  function [7:0] clamp9; // [RULE4]
    input [8:0] v;
    input [8:0] lo;
    input [8:0] hi;
    begin
      if ($signed(v) < $signed(lo))
        clamp9 = lo[7:0];
      else if ($signed(v) > $signed(hi))
        clamp9 = hi[7:0];
      else
        clamp9 = v[7:0];
    end
  endfunction

  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a[1:0] == 2'h0) && (a <= `CCD_ADDR_ROWTIME);
    end
  endfunction

  // configuration registers
  reg [7:0] first_row;
  reg [7:0] last_row;
  reg [13:0] gcfg;
  reg [31:0] gcode;
  reg [15:0] gpwr;
  reg [15:0] gtim;
  reg [7:0] row_sel;
  reg [8:0] pos_sel;

  // sequencer
  reg [5:0] state;
  reg [7:0] erow;
  reg [8:0] code_cur;
  reg [7:0] pwr_cur;
  reg [7:0] tim_cur;
  reg [6:0] ridx;
  reg [8:0] pos;
  reg in_row;
  reg [14:0] total;
  reg [9:0] cursor;
  reg [2:0] lvl;
  reg [127:0] row_on;
  reg [127:0] row_flag;

  // per row table and occupancy
  reg [8:0] code_mem [0:127];
  reg [2:0] rate_mem [0:127];
  reg [1:0] pil_mem [0:127];
  reg mc_mem [0:127];
  reg [2:0] dsrc_mem [0:127];
  reg [7:0] pwr_mem [0:127];
  reg [7:0] tim_mem [0:127];
  reg [1:0] occ_mem [0:511];

  wire setup = psel & ~penable;
  wire wr_acc = psel & penable & pwrite & addr_ok(paddr);
  wire idle = (state == S_IDLE);
  wire [2:0] grate = gcfg[`CCD_GCFG_RATE_LSB +: 3];
  wire [7:0] erow_off = erow - `CCD_ROW_MIN;
  wire [7:0] rsel_off = row_sel - `CCD_ROW_MIN;
  wire [6:0] eidx = erow_off[6:0];
  wire [6:0] sidx = rsel_off[6:0];
  wire [8:0] cstep = gcode[`CCD_GCODE_STEP_LSB +: 9];
  wire [8:0] pstep9 = {gpwr[15], gpwr[15:8]};
  wire [7:0] tstep = gtim[`CCD_GTIM_STEP_LSB +: 8];

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok(paddr);
  assign busy = ~idle;

  // current row in the scan, sum and assign passes
  wire [8:0] r_code = code_mem[ridx];
  wire [2:0] r_rate = rate_mem[ridx];
  wire r_on = row_on[ridx]; // [RULE25]
  wire [7:0] r_fac = dom_factor(r_rate);
  wire [8:0] r_low = r_code << r_rate; // [RULE15]
  wire [8:0] r_up = r_low + {1'b0, r_fac} - 9'h001; // [RULE16] [RULE12]
  wire [1:0] occ_cur = occ_mem[pos];
  wire [14:0] sum_next = total + (r_on ? {7'h00, r_fac} : 15'h0000);
  wire last_ridx = (ridx == 7'h7F);
  wire asg_hit = r_on && (r_rate == lvl);
  wire scan_hit = (state == S_SCAN) && in_row;

  // register writes; range rows refuse values outside 11..138
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_row <= `CCD_FIRST_RST;
      last_row <= `CCD_LAST_RST;
      gcfg <= `CCD_GCFG_RST;
      gcode <= `CCD_GCODE_RST;
      gpwr <= `CCD_GPWR_RST;
      gtim <= `CCD_GTIM_RST;
      row_sel <= `CCD_ROW_MIN;
      pos_sel <= 9'h000;
    end else if (wr_acc) begin
      case (paddr)
        `CCD_ADDR_FIRST: begin
          if (pwdata[7:0] >= `CCD_ROW_MIN && pwdata[7:0] <= `CCD_ROW_MAX &&
              pwdata[31:8] == 24'h000000)
            first_row <= pwdata[7:0]; // [RULE23]
        end
        `CCD_ADDR_LAST: begin
          if (pwdata[7:0] >= `CCD_ROW_MIN && pwdata[7:0] <= `CCD_ROW_MAX &&
              pwdata[31:8] == 24'h000000)
            last_row <= pwdata[7:0]; // [RULE23]
        end
        `CCD_ADDR_GCFG: gcfg <= pwdata[13:0];
        `CCD_ADDR_GCODE: gcode <= {7'h00, pwdata[24:16], 7'h00, pwdata[8:0]};
        `CCD_ADDR_GPWR: begin
          gpwr[7:0] <= clamp9({pwdata[7], pwdata[7:0]},
                              `CCD_PWR_MIN, `CCD_PWR_MAX); // [RULE4]
          gpwr[15:8] <= clamp9({pwdata[15], pwdata[15:8]},
                               `CCD_PSTEP_MIN, `CCD_PSTEP_MAX); // [RULE4]
        end
        `CCD_ADDR_GTIM: gtim <= pwdata[15:0];
        `CCD_ADDR_ROWSEL: begin
          if (pwdata[7:0] >= `CCD_ROW_MIN && pwdata[7:0] <= `CCD_ROW_MAX)
            row_sel <= pwdata[7:0];
        end
        `CCD_ADDR_POSSEL: pos_sel <= pwdata[8:0];
        default: begin
        end
      endcase
    end
  end

  // sequencer: reset starts with a clear so the occupancy is defined
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_CLEAR;
      erow <= `CCD_ROW_MIN;
      code_cur <= 9'h000;
      pwr_cur <= 8'h00;
      tim_cur <= 8'h00;
      ridx <= 7'h00;
      pos <= 9'h000;
      in_row <= 1'b0;
      total <= 15'h0000;
      cursor <= 10'h000;
      lvl <= 3'h7;
      row_on <= 128'h0;
      row_flag <= 128'h0;
      conflict <= 1'b0;
      unresolvable <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (wr_acc && paddr == `CCD_ADDR_CTRL) begin
            if (pwdata[`CCD_CTRL_EXEC] && first_row <= last_row) begin
              erow <= first_row;
              code_cur <= gcode[8:0]; // [RULE3]
              pwr_cur <= gpwr[7:0]; // [RULE4]
              tim_cur <= gtim[7:0]; // [RULE6]
              state <= S_EXEC;
            end else if (pwdata[`CCD_CTRL_RESOLVE]) begin
              unresolvable <= 1'b0;
              total <= 15'h0000;
              ridx <= 7'h00;
              state <= S_SUM;
            end
          end
        end
        S_EXEC: begin
          row_on[eidx] <= gcfg[`CCD_GCFG_STATE]; // [RULE8]
          if (erow == last_row) begin // [RULE10]
            pos <= 9'h000;
            state <= S_CLEAR; // [RULE24]
          end else begin
            erow <= erow + 8'h01;
            code_cur <= code_cur + cstep; // [RULE3]
            pwr_cur <= clamp9({pwr_cur[7], pwr_cur} + pstep9,
                              `CCD_PWR_MIN, `CCD_PWR_MAX); // [RULE4]
            tim_cur <= tim_cur + tstep; // [RULE6]
          end
        end
        S_CLEAR: begin
          row_flag <= 128'h0;
          conflict <= 1'b0;
          if (pos == `CCD_DOMAIN_LAST) begin
            ridx <= 7'h00;
            in_row <= 1'b0;
            state <= S_SCAN;
          end
          pos <= pos + 9'h001;
        end
        S_SCAN: begin
          if (!in_row) begin
            if (r_on) begin
              pos <= r_low;
              in_row <= 1'b1;
            end else if (last_ridx) begin
              state <= S_IDLE;
            end else begin
              ridx <= ridx + 7'h01;
            end
          end else begin
            // ascending rows: a taken position means a lower row overlaps
            if (occ_cur != 2'h0) begin
              row_flag[ridx] <= 1'b1; // [RULE19] [RULE17]
              conflict <= 1'b1; // [RULE18]
            end
            if (pos == r_up) begin
              in_row <= 1'b0;
              if (last_ridx)
                state <= S_IDLE;
              else
                ridx <= ridx + 7'h01;
            end else begin
              pos <= pos + 9'h001;
            end
          end
        end
        S_SUM: begin
          total <= sum_next;
          if (last_ridx) begin
            ridx <= 7'h00;
            if (sum_next > `CCD_DOMAIN_SIZE) begin
              unresolvable <= 1'b1; // [RULE22]
              state <= S_IDLE;
            end else begin
              cursor <= 10'h000;
              lvl <= 3'h7;
              state <= S_ASSIGN;
            end
          end else begin
            ridx <= ridx + 7'h01;
          end
        end
        S_ASSIGN: begin
          // widest channels first keeps every block aligned to its size
          if (asg_hit)
            cursor <= cursor + {2'h0, r_fac}; // [RULE21]
          ridx <= ridx + 7'h01;
          if (last_ridx) begin
            if (lvl == 3'h0) begin
              pos <= 9'h000;
              state <= S_CLEAR; // [RULE24]
            end else begin
              lvl <= lvl - 3'h1;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // table and occupancy storage, no reset; rebuilt by the sequencer
  wire [9:0] asg_code = cursor >> lvl;
  always @(posedge pclk) begin
    if (state == S_EXEC) begin
      code_mem[eidx] <= code_mask(code_cur, grate); // [RULE3]
      rate_mem[eidx] <= grate;
      pil_mem[eidx] <= pilot_fit(gcfg[`CCD_GCFG_PIL_LSB +: 2],
                                 grate); // [RULE1]
      mc_mem[eidx] <= gcfg[`CCD_GCFG_MCODE]; // [RULE9]
      dsrc_mem[eidx] <= gcfg[`CCD_GCFG_DSRC_LSB +: 3];
      pwr_mem[eidx] <= pwr_cur;
      tim_mem[eidx] <= tim_cur;
    end
    if (state == S_ASSIGN && asg_hit)
      code_mem[ridx] <= asg_code[8:0]; // [RULE21]
    if (state == S_CLEAR)
      occ_mem[pos] <= 2'h0; // [RULE24]
    if (scan_hit)
      occ_mem[pos] <= (occ_cur == 2'h0) ? 2'h1 : 2'h2; // [RULE24] [RULE20]
  end

  // readback of the selected row
  wire [2:0] s_rate = rate_mem[sidx];
  wire [1:0] s_pil = pil_mem[sidx];
  wire [10:0] s_slot = `CCD_SLOT_BITS_MIN << s_rate;
  wire [10:0] s_pbits = 11'h002 << s_pil;
  wire [10:0] s_data = s_slot - s_pbits; // [RULE2]
  wire [9:0] s_sf = `CCD_SF_MAX >> s_rate; // [RULE11]
  wire [15:0] s_delay = {tim_mem[sidx], 8'h00}; // [RULE5]
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `CCD_ADDR_STATUS: begin
        rd_mux[`CCD_STAT_BUSY] = ~idle;
        rd_mux[`CCD_STAT_CONFLICT] = conflict;
        rd_mux[`CCD_STAT_UNRES] = unresolvable;
      end
      `CCD_ADDR_FIRST: rd_mux[7:0] = first_row;
      `CCD_ADDR_LAST: rd_mux[7:0] = last_row;
      `CCD_ADDR_GCFG: rd_mux[13:0] = gcfg;
      `CCD_ADDR_GCODE: rd_mux = gcode;
      `CCD_ADDR_GPWR: rd_mux[15:0] = gpwr;
      `CCD_ADDR_GTIM: rd_mux[15:0] = gtim;
      `CCD_ADDR_ROWSEL: rd_mux[7:0] = row_sel;
      `CCD_ADDR_ROWDATA:
        rd_mux = {pwr_mem[sidx], 7'h00, row_flag[sidx], row_on[sidx],
                  mc_mem[sidx], s_pil, s_rate, code_mem[sidx]};
      `CCD_ADDR_ROWINFO:
        rd_mux = {dsrc_mem[sidx], s_data, s_sf, tim_mem[sidx]};
      `CCD_ADDR_POSSEL: rd_mux[8:0] = pos_sel;
      `CCD_ADDR_POSCNT: rd_mux[1:0] = occ_mem[pos_sel]; // [RULE20]
      `CCD_ADDR_ROWTIME: rd_mux[15:0] = s_delay; // [RULE5]
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data captured in the setup cycle, stable through access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= rd_mux;
  end

endmodule // ccd_checker

`default_nettype wire

// ### bench/ccd_checker_assertions.sv
// concurrent checks on the ports of the code domain checker
`timescale 1ns/1ps
`default_nettype none
module ccd_checker_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // status
  input wire logic conflict,
  input wire logic unresolvable,
  input wire logic busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic [15:0] bcnt;
  assign acc = psel && penable;
  // longest job: execute plus a full scan of 128 wide rows
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      bcnt <= 16'h0000;
    else
      bcnt <= busy ? bcnt + 16'h0001 : 16'h0000;
  end
  AST_READY: assert property (acc |-> pready)
    else $error("pready low in access phase");
  AST_BAD_ADDR: assert property (acc && (paddr > 8'h34 ||
      paddr[1:0] != 2'h0) |-> pslverr)
    else $error("no error on unmapped address");
  AST_GOOD_ADDR: assert property (acc && paddr <= 8'h34 &&
      paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped address");
  AST_RESOLVE_BUSY: assert property (
      acc && pwrite && paddr == 8'h00 && pwdata[1:0] == 2'h2 && !busy
      |=> busy [*8])
    else $error("resolve did not start");
  AST_RESET_CLEAN: assert property ($rose(presetn) |->
      busy && !conflict && !unresolvable)
    else $error("state not clean after reset");
  AST_CONF_HOLD: assert property (!busy && !$past(busy) |->
      $stable(conflict))
    else $error("conflict moved while idle");
  AST_UNRES_HOLD: assert property (!busy && !$past(busy) |->
      $stable(unresolvable))
    else $error("unresolvable moved while idle");
  AST_BUSY_BOUND: assert property (bcnt < 16'd20000)
    else $error("sequencer busy too long");
  C_EXEC: cover property (acc && pwrite && paddr == 8'h00 && pwdata[0]);
  C_CONF: cover property ($rose(conflict));
  C_UNRES: cover property ($rose(unresolvable));
endmodule // ccd_checker_sva
bind ccd_checker ccd_checker_sva i_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .conflict(conflict), .unresolvable(unresolvable), .busy(busy));
`default_nettype wire

// ### bench/tb.sv
// random and corner stimulus for the code domain checker
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd, v;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, conflict, unresolvable, busy;
  logic er;
  int errors, n_compared, seed, f;
  logic [8:0] m_code [11:138];
  logic [2:0] m_rate [11:138];
  logic m_act [11:138];
  logic [7:0] m_pw [11:138];
  logic [7:0] m_to [11:138];
  ccd_checker i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conflict(conflict), .unresolvable(unresolvable), .busy(busy));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic summarize;
    if (errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    penable <= 1'b0;
    psel <= 1'b0;
    @(posedge pclk);
    if (n >= 50) begin
      errors++;
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 20000);
    if (n >= 20000) begin
      errors++;
      summarize();
    end
  endtask
  function automatic int lo(input int r);
    return int'(m_code[r]) << m_rate[r];
  endfunction
  function automatic int hi(input int r);
    return lo(r) + (1 << m_rate[r]) - 1;
  endfunction
  // a row is flagged only against lower active rows
  function automatic logic flag(input int r);
    flag = 1'b0;
    for (int j = 11; j < r; j++)
      if (m_act[r] && m_act[j] && lo(j) <= hi(r) && lo(r) <= hi(j))
        flag = 1'b1;
  endfunction
  function automatic logic anyc;
    anyc = 1'b0;
    for (int r = 11; r <= 138; r++)
      anyc = anyc | flag(r);
  endfunction
  function automatic logic [1:0] occ(input int p);
    int c;
    c = 0;
    for (int r = 11; r <= 138; r++)
      if (m_act[r] && lo(r) <= p && p <= hi(r))
        c++;
    return c > 2 ? 2'd2 : 2'(c);
  endfunction
  task automatic round(input int f, l, input logic [2:0] rt,
                       input logic st, input logic [8:0] c0, cs);
    int p, ps, ep, k, r;
    logic [31:0] cf;
    logic [7:0] t0, ts;
    logic [1:0] pc, mx;
    cf = $random(seed) & 32'h1733;
    cf[2:0] = rt;
    cf[13] = st;
    p = -(($random(seed) & 63) % 61);
    ps = $random(seed) % 61;
    t0 = $random(seed);
    if (t0 == 8'h00)
      t0 = 8'h01;
    ts = $random(seed);
    mx = rt < 2 ? 2'd1 : rt < 4 ? 2'd2 : 2'd3;
    pc = cf[5:4] > mx ? mx : cf[5:4];
    wr(8'h08, f);
    wr(8'h0C, l);
    wr(8'h10, cf);
    wr(8'h14, {7'h0, cs, 7'h0, c0});
    wr(8'h18, {16'h0, ps[7:0], p[7:0]});
    wr(8'h1C, {16'h0, ts, t0});
    wr(8'h00, 32'h1);
    idle();
    ep = p;
    for (k = 0; k <= l - f; k++) begin
      r = f + k;
      if (k > 0)
        ep = ep + ps < -60 ? -60 : ep + ps > 0 ? 0 : ep + ps;
      m_code[r] = (c0 + k * cs) & (511 >> rt);
      m_rate[r] = rt;
      m_act[r] = st;
      m_pw[r] = ep[7:0];
      m_to[r] = t0 + k * ts;
    end
    for (r = f; r <= l; r++) begin
      wr(8'h20, r);
      apb(1'b0, 8'h24, 32'h0);
      chk(rd[8:0], m_code[r]);
      chk(rd[13:9], {pc, rt});
      chk(rd[14], cf[12]);
      chk(rd[15], st);
      chk(rd[23:16], {7'h0, flag(r)});
      chk(rd[31:24], m_pw[r]);
      apb(1'b0, 8'h28, 32'h0);
      chk(rd[31:29], cf[10:8]);
      chk(rd[28:18], (10 << rt) - (2 << pc));
      chk(rd[17:8], 512 >> rt);
      chk(rd[7:0], m_to[r]);
      rdc(8'h34, {16'h0, m_to[r], 8'h0});
    end
    apb(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h3, {30'h0, anyc(), 1'b0});
    chk({busy, conflict}, {1'b0, anyc()});
    for (k = 0; k < 4; k++) begin
      p = k == 0 ? lo(f) : k == 1 ? hi(f) : k == 2 ? hi(f) + 1 : $random(seed);
      wr(8'h2C, p & 511);
      apb(1'b0, 8'h30, 32'h0);
      chk(rd[1:0], occ(p & 511));
      chk(rd[31:2], 30'h0);
    end
  endtask
  task automatic res;
    int tot, r;
    logic bad;
    tot = 0;
    for (r = 11; r <= 138; r++)
      tot += m_act[r] ? 1 << m_rate[r] : 0;
    bad = tot > 512;
    wr(8'h00, 32'h2);
    idle();
    rdc(8'h04, {29'h0, bad, bad & anyc(), 1'b0});
    chk(unresolvable, bad);
    for (r = 11; r <= 138; r++) begin
      if (m_act[r]) begin
        wr(8'h20, r);
        apb(1'b0, 8'h24, 32'h0);
        chk(rd & 32'h8E00, {16'h0, 1'b1, 3'h0, m_rate[r], 9'h0});
        if (bad)
          chk(rd[8:0], m_code[r]);
        m_code[r] = rd[8:0];
        chk(hi(r) <= 511, 1'b1);
        chk(rd[16], flag(r));
      end
    end
    chk(anyc(), 1'(bad));
  endtask
  initial begin
    seed = 32'hf41321b3;
    errors = 0;
    n_compared = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    for (int i = 11; i <= 138; i++)
      m_act[i] = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    idle();
    rdc(8'h10, 32'h2212);
    rdc(8'h0C, 32'h0B);
    wr(8'h08, 32'h0A);
    rdc(8'h08, 32'h0B);
    wr(8'h08, 32'h8B);
    rdc(8'h08, 32'h0B);
    wr(8'h0C, 32'h8A);
    rdc(8'h0C, 32'h8A);
    wr(8'h18, 32'h46BA);
    rdc(8'h18, 32'h3CC4);
    rdc(8'h38, 32'h0);
    chk(er, 32'h1);
    round(16, 23, 3'd2, 1'b1, 9'd0, 9'd0);
    res();
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      f = 11 + (($random(seed) & 127) % 120);
      round(f, f + v[18:16], 3'(i), v[24], v[8:0], {3'h0, v[30:25]});
    end
    round(11, 15, 3'd7, 1'b1, 9'd0, 9'd0);
    res();
    summarize();
  end
endmodule // tb
`default_nettype wire
